/* File: core/sse_cache_if.sv */
`timescale 1ns/1ps
interface sse_cache_if #(parameter int IDX_W = 4);
  logic wrEn;
  logic wrSel;
  logic [IDX_W-1:0] wrIdx;
  logic [31:0] wrTag;
  logic [31:0] wrData;
  logic rdSel;
  logic [IDX_W-1:0] rdIdx;
  logic [31:0] rdTag;
  logic [31:0] rdData;
  modport exec (
    output wrEn, wrSel, wrIdx, wrTag, wrData, rdSel, rdIdx,
    input rdTag, rdData
  );
  modport mem (
    input wrEn, wrSel, wrIdx, wrTag, wrData, rdSel, rdIdx,
    output rdTag, rdData
  );
endinterface

/* File: core/sse_cache_mem.sv */
`timescale 1ns/1ps
module sse_cache_mem #(
  parameter int IDX_W = 4
) (
  input wire logic clk,
  sse_cache_if.mem cif
);
  // entry = {tag, data}; upper half of the array is the icache
  localparam int DEPTH = 2 << IDX_W;

  typedef struct packed {
    logic [31:0] rdTag;
    logic [31:0] rdData;
  } sse_mem_regs_t;

  logic [63:0] store [DEPTH];
  sse_mem_regs_t r_reg;
  sse_mem_regs_t r_next;

  always_comb begin
    r_next = r_reg;
    {r_next.rdTag, r_next.rdData} = store[{cif.rdSel, cif.rdIdx}];
  end

  always_ff @(posedge clk) begin
    r_reg <= r_next;
    if (cif.wrEn) begin
      store[{cif.wrSel, cif.wrIdx}] <= {cif.wrTag, cif.wrData};
    end
  end

  assign cif.rdTag = r_reg.rdTag;
  assign cif.rdData = r_reg.rdData;
endmodule

/* File: core/sse_consts.svh */
`ifndef SSE_CONSTS_SVH
`define SSE_CONSTS_SVH

// ===========================================================
// register offsets (byte addresses)
`define SSE_OFF_CMD 8'h00
`define SSE_OFF_SRCA 8'h04
`define SSE_OFF_SRCB 8'h08
`define SSE_OFF_DATA 8'h0C
`define SSE_OFF_IMM 8'h10
`define SSE_OFF_PREFIX 8'h14
`define SSE_OFF_MSW 8'h18
`define SSE_OFF_RESULT 8'h1C
`define SSE_OFF_STATUS 8'h20
`define SSE_OFF_CIDX 8'h24
`define SSE_OFF_CDATA 8'h28
`define SSE_OFF_CTAG 8'h2C

// ===========================================================
// field positions
`define SSE_MSW_CARRY 0
`define SSE_MSW_ICEN 1
`define SSE_MSW_DCEN 2
`define SSE_STAT_BUSY 0
`define SSE_STAT_PREFIX 1
`define SSE_STAT_REFUSED 2
`define SSE_CIDX_SEL 8
`define SSE_TAG_VALID 1
`define SSE_TAG_LOCK 0
`define SSE_HALF_SIGN 15
`define SSE_BYTE_SIGN 7
`define SSE_OP_W 4

// ===========================================================
// reset values
`define SSE_RST_WORD 32'h0000_0000
`define SSE_RST_HALF 16'h0000

`endif

/* File: core/sse_exec.sv */
`timescale 1ns/1ps
`include "sse_consts.svh"

// How it works
// - halfword extend copies bit 16 upward
// - byte extend copies bit 24 upward
// - arithmetic shift keeps sign in bit 0
// - carry shift puts carry into bit 0
// - logical shift puts zero into bit 0
// - all shifts load carry from bit 31
// - register halfword store, address bit 31 cleared
// - immediate halfword store, address bit 31 cleared
// - register word store, bits 30-31 cleared
// - immediate word store, bits 30-31 cleared
// - immediate sign-extends unless prefix supplies upper
// - data cache write: tag, data, valid, lock
// - data cache write only while disabled
// - instruction cache write: tag, data, flags
// - instruction cache write only while disabled
// - register xor leaves carry alone
// - immediate xor zero-extends its immediate
module sse_exec #(
  parameter int IDX_W = 4,
  parameter bit XORI_SIGN_EXT = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic memWrStrobe,
  output logic [31:0] memAddr,
  output logic [31:0] memWrData,
  output logic [3:0] memByteEn
);
  import sse_pkg::*;

  typedef struct packed {
    sse_state_t state;
    logic [31:0] firstSrc;
    logic [31:0] secondSrc;
    logic [31:0] dataSrc;
    logic [15:0] imm;
    logic [15:0] prefix;
    logic prefixValid;
    logic carry;
    logic icEn;
    logic dcEn;
    logic refused;
    logic [31:0] result;
    logic memStb;
    logic [31:0] memAddr;
    logic [31:0] memData;
    logic [3:0] memBe;
    logic cacheWr;
    logic cacheSel;
    logic [31:0] cacheTag;
    logic [31:0] cacheData;
    logic [IDX_W-1:0] cacheIdx;
    logic rdSel;
    logic [IDX_W-1:0] rdIdx;
    logic [31:0] prdata;
    logic slverr;
  } sse_regs_t;

  sse_regs_t r_reg;
  sse_regs_t r_next;

  sse_cache_if #(.IDX_W(IDX_W)) cif ();

  sse_cache_mem #(.IDX_W(IDX_W)) u_mem (
    .clk(clk),
    .cif(cif)
  );

  // ===========================================================
  // decoding helpers
  function automatic logic isMapped(input logic [7:0] a);
    case (a)
      `SSE_OFF_CMD, `SSE_OFF_SRCA, `SSE_OFF_SRCB, `SSE_OFF_DATA,
      `SSE_OFF_IMM, `SSE_OFF_PREFIX, `SSE_OFF_MSW,
      `SSE_OFF_RESULT, `SSE_OFF_STATUS, `SSE_OFF_CIDX,
      `SSE_OFF_CDATA, `SSE_OFF_CTAG: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] extImm(
    input logic [15:0] imm,
    input logic [15:0] prefix,
    input logic prefixValid,
    input logic zeroExt
  );
    if (prefixValid) begin
      extImm = {prefix, imm};
    end else if (zeroExt) begin
      extImm = {16'h0000, imm};
    end else begin
      extImm = {{16{imm[15]}}, imm};
    end
  endfunction

  // doc bit n is vector bit 31-n
  function automatic logic [31:0] shiftRight(
    input logic [31:0] src,
    input logic topIn
  );
    shiftRight = {topIn, src[31:1]};
  endfunction

  function automatic logic [31:0] readWord(
    input logic [7:0] a,
    input sse_regs_t r,
    input logic [31:0] cTag,
    input logic [31:0] cData
  );
    logic [31:0] w;
    w = `SSE_RST_WORD;
    case (a)
      `SSE_OFF_SRCA: w = r.firstSrc;
      `SSE_OFF_SRCB: w = r.secondSrc;
      `SSE_OFF_DATA: w = r.dataSrc;
      `SSE_OFF_IMM: w[15:0] = r.imm;
      `SSE_OFF_PREFIX: w[15:0] = r.prefix;
      `SSE_OFF_MSW: begin
        w[`SSE_MSW_CARRY] = r.carry;
        w[`SSE_MSW_ICEN] = r.icEn;
        w[`SSE_MSW_DCEN] = r.dcEn;
      end
      `SSE_OFF_RESULT: w = r.result;
      `SSE_OFF_STATUS: begin
        w[`SSE_STAT_BUSY] = (r.state != SSE_IDLE);
        w[`SSE_STAT_PREFIX] = r.prefixValid;
        w[`SSE_STAT_REFUSED] = r.refused;
      end
      `SSE_OFF_CIDX: begin
        w[IDX_W-1:0] = r.rdIdx;
        w[`SSE_CIDX_SEL] = r.rdSel;
      end
      `SSE_OFF_CDATA: w = cData;
      `SSE_OFF_CTAG: w = cTag;
      default: w = `SSE_RST_WORD;
    endcase
    readWord = w;
  endfunction

  // ===========================================================
  // next-state logic
  logic setupPhase;
  logic wrAccess;
  logic [31:0] regSum;
  logic [31:0] immSum;
  logic [31:0] immOperand;
  logic [31:0] xoriOperand;
  logic [IDX_W-1:0] lineIdx;
  sse_op_t op;

  assign setupPhase = psel & ~penable;
  assign wrAccess = psel & penable & pwrite & isMapped(paddr);
  assign op = sse_op_t'(pwdata[`SSE_OP_W-1:0]);
  assign immOperand = extImm(r_reg.imm, r_reg.prefix,
                             r_reg.prefixValid, 1'b0);
  // zero extension unless the parameter asks otherwise
  assign xoriOperand = extImm(r_reg.imm, r_reg.prefix,
                              r_reg.prefixValid, ~XORI_SIGN_EXT);
  assign regSum = r_reg.firstSrc + r_reg.secondSrc;
  assign immSum = r_reg.firstSrc + immOperand;
  // index from the word address bits just above the byte offset
  assign lineIdx = r_reg.firstSrc[IDX_W+1:2];

  always_comb begin
    r_next = r_reg;
    r_next.memStb = 1'b0;
    r_next.cacheWr = 1'b0;

    // read data is captured in the setup cycle so it leaves a flop
    if (setupPhase) begin
      r_next.prdata = readWord(paddr, r_reg, cif.rdTag, cif.rdData);
      r_next.slverr = ~isMapped(paddr);
    end

    case (r_reg.state)
      SSE_IDLE: r_next.state = SSE_IDLE;
      SSE_STORE: begin
        r_next.memStb = 1'b1;
        r_next.state = SSE_IDLE;
      end
      default: r_next.state = SSE_IDLE;
    endcase

    if (wrAccess) begin
      case (paddr)
        `SSE_OFF_SRCA: r_next.firstSrc = pwdata;
        `SSE_OFF_SRCB: r_next.secondSrc = pwdata;
        `SSE_OFF_DATA: r_next.dataSrc = pwdata;
        `SSE_OFF_IMM: r_next.imm = pwdata[15:0];
        `SSE_OFF_PREFIX: begin
          r_next.prefix = pwdata[15:0];
          r_next.prefixValid = 1'b1;
        end
        `SSE_OFF_MSW: begin
          r_next.carry = pwdata[`SSE_MSW_CARRY];
          r_next.icEn = pwdata[`SSE_MSW_ICEN];
          r_next.dcEn = pwdata[`SSE_MSW_DCEN];
        end
        `SSE_OFF_STATUS: begin
          if (pwdata[`SSE_STAT_REFUSED]) begin
            r_next.refused = 1'b0;
          end
        end
        `SSE_OFF_CIDX: begin
          r_next.rdIdx = pwdata[IDX_W-1:0];
          r_next.rdSel = pwdata[`SSE_CIDX_SEL];
        end
        `SSE_OFF_CMD: begin
          if (r_reg.state != SSE_IDLE) begin
            // a command during a store cycle is dropped, not queued
            r_next.refused = 1'b1;
          end else begin
            // the prefix only covers the very next command
            r_next.prefixValid = 1'b0;
            case (op)
              SSE_OP_SIGN_EXTEND_HALF_OP: r_next.result = {
                {16{r_reg.firstSrc[`SSE_HALF_SIGN]}},
                r_reg.firstSrc[15:0]};
              SSE_OP_SIGN_EXTEND_BYTE_OP: r_next.result = {
                {24{r_reg.firstSrc[`SSE_BYTE_SIGN]}},
                r_reg.firstSrc[7:0]};
              SSE_OP_SRA: begin
                r_next.result = shiftRight(r_reg.firstSrc,
                                           r_reg.firstSrc[31]);
                r_next.carry = r_reg.firstSrc[0];
              end
              SSE_OP_SRC: begin
                r_next.result = shiftRight(r_reg.firstSrc,
                                           r_reg.carry);
                r_next.carry = r_reg.firstSrc[0];
              end
              SSE_OP_SRL: begin
                r_next.result = shiftRight(r_reg.firstSrc, 1'b0);
                r_next.carry = r_reg.firstSrc[0];
              end
              SSE_OP_SH, SSE_OP_SHI: begin
                r_next.memAddr = {regSum[31:1], 1'b0};
                if (op == SSE_OP_SHI) begin
                  r_next.memAddr = {immSum[31:1], 1'b0};
                end
                r_next.memData = {r_reg.dataSrc[15:0],
                                  r_reg.dataSrc[15:0]};
                r_next.memBe = r_next.memAddr[1] ? 4'h3 : 4'hC;
                r_next.state = SSE_STORE;
              end
              SSE_OP_SW, SSE_OP_SWI: begin
                r_next.memAddr = {regSum[31:2], 2'b00};
                if (op == SSE_OP_SWI) begin
                  r_next.memAddr = {immSum[31:2], 2'b00};
                end
                r_next.memData = r_reg.dataSrc;
                r_next.memBe = 4'hF;
                r_next.state = SSE_STORE;
              end
              SSE_OP_WDC, SSE_OP_WIC: begin
                if ((op == SSE_OP_WDC) ? r_reg.dcEn : r_reg.icEn) begin
                  r_next.refused = 1'b1;
                end else begin
                  // tag word carries valid and lock
                  r_next.cacheWr = 1'b1;
                  r_next.cacheSel = (op == SSE_OP_WIC);
                  r_next.cacheIdx = lineIdx;
                  r_next.cacheTag = r_reg.firstSrc;
                  r_next.cacheData = r_reg.secondSrc;
                end
              end
              SSE_OP_XOR: r_next.result =
                r_reg.firstSrc ^ r_reg.secondSrc;
              SSE_OP_XORI: r_next.result =
                r_reg.firstSrc ^ xoriOperand;
              // unknown opcodes raise the refusal flag and also drop any pending prefix
              default: r_next.refused = 1'b1;
            endcase
          end
        end
        default: r_next.refused = r_next.refused;
      endcase
    end

    if (rst) begin
      r_next = '0;
      r_next.state = SSE_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    r_reg <= r_next;
  end

  // ===========================================================
  // outputs
  // zero wait states: every readable value already sits in a flop
  assign pready = 1'b1;
  assign prdata = r_reg.prdata;
  assign pslverr = r_reg.slverr & psel & penable;
  // store address, data and lanes stay on the pins until the next store replaces them; the strobe lasts one cycle
  assign memWrStrobe = r_reg.memStb;
  assign memAddr = r_reg.memAddr;
  assign memWrData = r_reg.memData;
  assign memByteEn = r_reg.memBe;

  // the array takes the registered request one edge after the command
  assign cif.wrEn = r_reg.cacheWr;
  assign cif.wrSel = r_reg.cacheSel;
  assign cif.wrIdx = r_reg.cacheIdx;
  assign cif.wrTag = r_reg.cacheTag;
  assign cif.wrData = r_reg.cacheData;
  assign cif.rdSel = r_reg.rdSel;
  assign cif.rdIdx = r_reg.rdIdx;
endmodule

/* File: core/sse_pkg.sv */
package sse_pkg;
  typedef enum logic [3:0] {
    SSE_OP_SIGN_EXTEND_HALF_OP = 4'h0,
    SSE_OP_SIGN_EXTEND_BYTE_OP = 4'h1,
    SSE_OP_SRA = 4'h2,
    SSE_OP_SRC = 4'h3,
    SSE_OP_SRL = 4'h4,
    SSE_OP_SH = 4'h5,
    SSE_OP_SHI = 4'h6,
    SSE_OP_SW = 4'h7,
    SSE_OP_SWI = 4'h8,
    SSE_OP_WDC = 4'h9,
    SSE_OP_WIC = 4'hA,
    SSE_OP_XOR = 4'hB,
    SSE_OP_XORI = 4'hC
  } sse_op_t;

  typedef enum logic [1:0] {
    SSE_IDLE = 2'b01,
    SSE_STORE = 2'b10
  } sse_state_t;
endpackage

/* File: testbench/shift_extend_store_xor_exec_bench.sv */
`timescale 1ns/1ps
module shift_extend_store_xor_exec_bench;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, memWrStrobe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, memAddr, memWrData, q;
  logic [3:0] memByteEn;
  logic qErr;
  int failures, checksDone, cycles, k;
  sse_exec dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .memWrStrobe, .memAddr, .memWrData,
    .memByteEn);
  sse_mem_model mm (.clk, .rst, .memWrStrobe, .memAddr, .memWrData,
    .memByteEn);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // reporting
  task automatic print_verdict();
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    checksDone++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // ==========================================================
  // bus access: the release edge is kept apart from the next setup
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    qErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic run(input logic [3:0] op, input logic [31:0] a, b);
    apb(1'b1, 8'h04, a);
    apb(1'b1, 8'h08, b);
    apb(1'b1, 8'h00, {28'h0, op});
  endtask
  task automatic alu(input logic [3:0] op, input logic [31:0] a, b, r,
    input logic ci, co);
    apb(1'b1, 8'h18, {31'h0, ci});
    run(op, a, b);
    apb(1'b0, 8'h1C, 32'h0);
    chk("result", q, r);
    apb(1'b0, 8'h18, 32'h0);
    chk("carry", q, {31'h0, co});
  endtask
  task automatic st(input logic [3:0] op, input logic [31:0] a, b, i, ea,
    ed, input logic [3:0] eb);
    logic [31:0] c0;
    c0 = 32'(mm.count);
    apb(1'b1, 8'h10, i);
    apb(1'b1, 8'h0C, 32'hA1B2_C3D4);
    run(op, a, b);
    repeat (3) @(posedge clk);
    chk("stores", 32'(mm.count), c0 + 32'h1);
    chk("addr", mm.lastAddr, ea);
    chk("data", mm.lastData, ed);
    chk("lanes", {28'h0, mm.lastBe}, {28'h0, eb});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 8'h18, 32'h0);
    chk("status word", q, 32'h0);
    alu(4'h0, 32'h1234_8001, 32'h0, 32'hFFFF_8001, 1'b1, 1'b1);
    alu(4'h1, 32'hABCD_EF7F, 32'h0, 32'h0000_007F, 1'b0, 1'b0);
    alu(4'h2, 32'h8000_0001, 32'h0, 32'hC000_0000, 1'b0, 1'b1);
    alu(4'h3, 32'h0000_0002, 32'h0, 32'h8000_0001, 1'b1, 1'b0);
    alu(4'h4, 32'hFFFF_FFFF, 32'h0, 32'h7FFF_FFFF, 1'b0, 1'b1);
    // carry in is 0 and source bit 0 is 1: a stray carry load shows up
    alu(4'hB, 32'hF0F000FF, 32'h0FF00F0F, 32'hFF000FF0, 1'b0, 1'b0);
    apb(1'b1, 8'h10, 32'h0000_8001);
    alu(4'hC, 32'h0000_0001, 32'h0, 32'h0000_8000, 1'b0, 1'b0);
    apb(1'b1, 8'h14, 32'h0000_1234);
    apb(1'b1, 8'h10, 32'h0000_5678);
    apb(1'b0, 8'h20, 32'h0);
    chk("prefix pending", q & 32'h2, 32'h2);
    alu(4'hC, 32'hFFFF_0000, 32'h0, 32'hEDCB_5678, 1'b0, 1'b0);
    st(4'h7, 32'h103, 32'h2, 32'h0, 32'h104, 32'hA1B2_C3D4, 4'hF);
    st(4'h8, 32'h100, 32'h0, 32'hFFFE, 32'hFC, 32'hA1B2_C3D4, 4'hF);
    st(4'h5, 32'h101, 32'h2, 32'h0, 32'h102, 32'hC3D4_C3D4, 4'h3);
    st(4'h6, 32'h10, 32'h0, 32'h1, 32'h10, 32'hC3D4_C3D4, 4'hC);
    // second pass of the loop targets the instruction cache
    for (k = 0; k < 2; k++) begin
      apb(1'b1, 8'h18, 32'h0);
      run(k ? 4'hA : 4'h9, 32'h0000_000B, 32'h1111_2222 + k);
      apb(1'b1, 8'h18, k ? 32'h2 : 32'h4);
      run(k ? 4'hA : 4'h9, 32'h0000_000B, 32'h0BAD_0000);
      apb(1'b0, 8'h20, 32'h0);
      chk("refused", q & 32'h4, 32'h4);
      apb(1'b1, 8'h20, 32'h4);
      apb(1'b1, 8'h24, 32'(k << 8) | 32'h2);
      apb(1'b0, 8'h28, 32'h0);
      chk("cache data", q, 32'h1111_2222 + k);
      apb(1'b0, 8'h2C, 32'h0);
      chk("cache tag", q, 32'h0000_000B);
    end
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped", q, 32'h0);
    chk("slave error", {31'h0, qErr}, 32'h1);
    apb(1'b1, 8'h00, 32'h0000_000F);
    apb(1'b0, 8'h20, 32'h0);
    chk("bad opcode", q & 32'h4, 32'h4);
    chk("mapped error", {31'h0, qErr}, 32'h0);
    print_verdict();
  end
endmodule

/* File: testbench/sse_exec_checker.sv */
`timescale 1ns/1ps
module sse_exec_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic memWrStrobe,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWrData,
  input wire logic [3:0] memByteEn
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic storeReq;
  logic halfSt;
  assign storeReq = psel && penable && pwrite && paddr == 8'h00
    && pwdata[3:0] >= 4'h5 && pwdata[3:0] <= 4'h8;
  assign halfSt = memWrStrobe && memByteEn != 4'hF;
  // ==========================================================
  // store timing
  sequence storeCmd;
    storeReq;
  endsequence
  sequence strobeOnce;
    !memWrStrobe ##1 memWrStrobe ##1 !memWrStrobe;
  endsequence
  chk_store_launch: assert property (storeCmd |=> strobeOnce)
    else $error("store strobe missing or not one cycle");
  chk_store_cause: assert property ($rose(memWrStrobe)
    |-> $past(storeReq, 2))
    else $error("store strobe without store command");
  // reset clears the address too, so skip the edge right after it
  chk_addr_load: assert property ($changed(memAddr) && !$past(rst)
    |-> ##1 memWrStrobe)
    else $error("store address changed without a store");
  // ==========================================================
  // alignment, lanes and slave errors
  chk_word_align: assert property (memWrStrobe && memByteEn == 4'hF
    |-> memAddr[1:0] == 2'b00)
    else $error("word store not word aligned");
  chk_half_lane: assert property (halfSt |-> !memAddr[0]
    && memByteEn == (memAddr[1] ? 4'h3 : 4'hC))
    else $error("halfword store lane or alignment wrong");
  chk_half_copy: assert property (halfSt
    |-> memWrData[31:16] == memWrData[15:0])
    else $error("halfword store data not in both halves");
  chk_unmapped_err: assert property (psel && penable && paddr > 8'h2C
    |-> pslverr)
    else $error("unmapped access without slave error");
  chk_mapped_clean: assert property (psel && penable && paddr <= 8'h2C
    && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("slave error on a mapped register");
endmodule

bind sse_exec sse_exec_checker chk (.clk, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .memWrStrobe, .memAddr,
  .memWrData, .memByteEn);

/* File: testbench/sse_mem_model.sv */
`timescale 1ns/1ps
module sse_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic memWrStrobe,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWrData,
  input wire logic [3:0] memByteEn
);
  // ==========================================================
  // write-only port: nothing returns, so only the last store is kept
  logic [31:0] lastAddr;
  logic [31:0] lastData;
  logic [3:0] lastBe;
  int count;
  always @(posedge clk) begin
    if (rst) begin
      count <= 0;
    end else if (memWrStrobe) begin
      lastAddr <= memAddr;
      lastData <= memWrData;
      lastBe <= memByteEn;
      count <= count + 1;
    end
  end
endmodule
